// ---- rtl/daoc_pkg.sv ----
package daoc_pkg;
  // ----------------------------------------------------------------
  // widths and clock
  // ----------------------------------------------------------------
  localparam int SAMPLE_W     = 12;
  localparam int SAMPLE_MSPS  = 500;
  localparam int CLK_MHZ      = 100;
  localparam int CFG_W        = 24;
  localparam int ST_W         = 4;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] INFO_OFS = 8'h0c;
  localparam logic [CFG_W-1:0] CTRL_RST = 24'h000000;
  localparam logic [ST_W-1:0]  MASK_RST = 4'h0;
  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int B_PWRDN   = 0;
  localparam int B_SYNCOFF = 1;
  localparam int B_DECIM   = 2;
  localparam int B_AUTOCOR = 3;
  localparam int B_EDGEA   = 4;
  localparam int B_EDGEB   = 5;
  localparam int B_BONA    = 6;
  localparam int B_OVRASYN = 7;
  localparam int B_OVRBSYN = 8;
  localparam int B_FOURW   = 16;
  // ----------------------------------------------------------------
  // status field positions
  // ----------------------------------------------------------------
  localparam int ST_OVRA  = 0;
  localparam int ST_OVRB  = 1;
  localparam int ST_SYNC  = 2;
  localparam int ST_SERWR = 3;
  // ----------------------------------------------------------------
  // timing counts in clk cycles, frame sizes in serial bits
  // ----------------------------------------------------------------
  localparam int LAT_PLAIN   = 38;
  localparam int LAT_AUTO    = 50;
  localparam int LAT_DECIM   = 74;
  localparam int LAT_OVR     = 12;
  localparam int SYNC_PERIOD = 16;
  localparam int HDR_BITS    = 8;
  localparam int FRAME_BITS  = 32;
endpackage

// ---- rtl/daoc_cfg_if.sv ----
`timescale 1ns/1ps
interface daoc_cfg_if;
  import daoc_pkg::*;
  logic             we;
  logic [CFG_W-1:0] wdata;
  logic [CFG_W-1:0] rdata;
  logic             fourWire;
  modport port (output we, output wdata, input rdata, input fourWire);
  modport core (input we, input wdata, output rdata, output fourWire);
endinterface

// ---- rtl/daoc_serial_port.sv ----
`timescale 1ns/1ps
module daoc_serial_port
  import daoc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic serialClock,
  input  wire logic serialSelect,
  input  wire logic serialDataIn,
  output logic      ioOut,
  output logic      ioOe,
  output logic      outOe,
  daoc_cfg_if.port  cfg
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic sclkS1, sclkS2, sclkS3, selS1, selS2, dinS1, dinS2;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {sclkS1, sclkS2, sclkS3} <= 3'h0;
      {selS1, selS2, dinS1, dinS2} <= 4'h0;
    end else if (ce) begin
      sclkS1 <= serialClock;
      sclkS2 <= sclkS1;
      sclkS3 <= sclkS2;
      selS1  <= serialSelect;
      selS2  <= selS1;
      dinS1  <= serialDataIn;
      dinS2  <= dinS1;
    end
  end
  logic sclkRise, sclkFall;
  assign sclkRise = sclkS2 & ~sclkS3;
  assign sclkFall = ~sclkS2 & sclkS3;
  // ----------------------------------------------------------------
  // frame engine
  // ----------------------------------------------------------------
  logic [5:0]       bitCnt_q;
  logic [22:0]      shiftIn_q;
  logic             isRead_q, addrHit_q, dataOut_q, ioOe_q, outOe_q, we_q;
  logic [CFG_W-1:0] outShift_q, wdata_q;
  logic             readPhase;
  assign readPhase = isRead_q && (bitCnt_q >= 6'(HDR_BITS));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt_q   <= 6'h00;
      shiftIn_q  <= 23'h000000;
      isRead_q   <= 1'b0;
      addrHit_q  <= 1'b0;
      outShift_q <= 24'h000000;
      dataOut_q  <= 1'b0;
      we_q       <= 1'b0;
      wdata_q    <= 24'h000000;
    end else if (ce) begin
      we_q <= 1'b0;
      if (!selS2) begin
        bitCnt_q <= 6'h00;
        isRead_q <= 1'b0;
      end else if (sclkRise && bitCnt_q != 6'(FRAME_BITS)) begin
        bitCnt_q  <= bitCnt_q + 6'h01;
        shiftIn_q <= {shiftIn_q[21:0], dinS2};
        if (bitCnt_q == 6'(HDR_BITS - 1)) begin
          isRead_q   <= shiftIn_q[6];
          addrHit_q  <= ({shiftIn_q[5:0], dinS2} == 7'h00);
          dataOut_q  <= cfg.rdata[CFG_W-1];
          outShift_q <= {cfg.rdata[CFG_W-2:0], 1'b0};
        end
        if (bitCnt_q == 6'(FRAME_BITS - 1) && !isRead_q && addrHit_q) begin
          we_q    <= 1'b1;
          wdata_q <= {shiftIn_q, dinS2};
        end
      end else if (sclkFall && readPhase && bitCnt_q > 6'(HDR_BITS)) begin
        dataOut_q  <= outShift_q[CFG_W-1];
        outShift_q <= {outShift_q[CFG_W-2:0], 1'b0};
      end
    end
  end
  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ioOe_q  <= 1'b0;
      outOe_q <= 1'b0;
    end else if (ce) begin
      ioOe_q  <= selS2 && readPhase && !cfg.fourWire;
      outOe_q <= selS2 && readPhase && cfg.fourWire;
    end
  end
  assign ioOut     = dataOut_q;
  assign ioOe      = ioOe_q;
  assign outOe     = outOe_q;
  assign cfg.we    = we_q;
  assign cfg.wdata = wdata_q;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_four_wire_in: assert property (@(posedge clk) disable iff (!rst_n)
    cfg.fourWire |-> !ioOe_q) else $error("data pin driven in four-wire mode");
  a_three_wire_out: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg.fourWire |-> !outOe_q) else $error("output pin driven in three-wire mode");
  a_read_drive_pin: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    selS2 && readPhase && !cfg.fourWire |=> ioOe_q) else $error("read data not driven");
endmodule

// ---- rtl/daoc_core.sv ----
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module daoc_core
  import daoc_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic                     irq,
  input  wire logic                chipEnable,
  input  wire logic                syncIn,
  input  wire logic                serialPortReset_n,
  input  wire logic                serialClock,
  input  wire logic                serialSelect,
  input  wire logic                serialDataIn,
  output logic                     serialDataIoOut,
  output logic                     serialDataIoOe,
  output logic                     serialDataOut,
  output logic                     serialDataOutOe,
  input  wire logic [SAMPLE_W-1:0] chanAData,
  input  wire logic [SAMPLE_W-1:0] chanBData,
  input  wire logic                chanAOver,
  input  wire logic                chanBOver,
  output logic      [SAMPLE_W-1:0] busASample,
  output logic      [SAMPLE_W-1:0] busBSample,
  output logic                     busAFwdClock,
  output logic                     busBFwdClock,
  output logic                     chanAOverrange,
  output logic                     chanBOverrange,
  output logic                     syncOut
);
  localparam int DW = 2 * SAMPLE_W;
  // ----------------------------------------------------------------
  // serial control port
  // ----------------------------------------------------------------
  daoc_cfg_if cfgBus ();
  daoc_serial_port u_serial (
    .clk          (clk),
    .rst_n        (rst_n),
    .ce           (ce),
    .serialClock  (serialClock),
    .serialSelect (serialSelect),
    .serialDataIn (serialDataIn),
    .ioOut        (serialDataIoOut),
    .ioOe         (serialDataIoOe),
    .outOe        (serialDataOutOe),
    .cfg          (cfgBus.port)
  );
  assign serialDataOut = serialDataIoOut;
  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  logic [CFG_W-1:0] ctrl_q;
  logic             cfgRst_n, apbWr, apbSetup;
  assign cfgRst_n = rst_n & serialPortReset_n;
  assign apbSetup = psel & ~penable;
  assign apbWr    = psel & penable & pready & pwrite;
  always_ff @(posedge clk or negedge cfgRst_n) begin
    if (!cfgRst_n) begin
      ctrl_q <= CTRL_RST;
    end else if (ce) begin
      if (cfgBus.we) begin
        ctrl_q <= cfgBus.wdata;
      end else if (apbWr && paddr == CTRL_OFS) begin
        ctrl_q <= pwdata[CFG_W-1:0];
      end
    end
  end
  assign cfgBus.rdata    = ctrl_q;
  assign cfgBus.fourWire = ctrl_q[B_FOURW];
  logic decimEn, autoCor, edgeA, edgeB, bOnA;
  assign decimEn = ctrl_q[B_DECIM];
  assign autoCor = ctrl_q[B_AUTOCOR];
  assign edgeA   = ctrl_q[B_EDGEA];
  assign edgeB   = ctrl_q[B_EDGEB];
  assign bOnA    = ctrl_q[B_BONA];
  // ----------------------------------------------------------------
  // pin synchronisers and sync start
  // ----------------------------------------------------------------
  logic syncS1, syncS2, syncS3, enS1, enS2;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {syncS1, syncS2, syncS3, enS1, enS2} <= 5'h00;
    end else if (ce) begin
      syncS1 <= syncIn;
      syncS2 <= syncS1;
      syncS3 <= syncS2;
      enS1   <= chipEnable;
      enS2   <= enS1;
    end
  end
  logic       syncRun_q;
  logic syncStart, active;
  assign syncStart = syncS2 & ~syncS3 & ~syncRun_q;
  assign active    = enS2 & ~ctrl_q[B_PWRDN];
  logic [4:0] syncCnt_q;
  logic       syncNow;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncRun_q <= 1'b0;
      syncCnt_q <= 5'h00;
    end else if (ce) begin
      if (syncStart) begin
        syncRun_q <= 1'b1;
        syncCnt_q <= 5'h00;
      end else if (syncRun_q) begin
        syncCnt_q <= (syncCnt_q == 5'(SYNC_PERIOD - 1)) ? 5'h00 : syncCnt_q + 5'h01;
      end
    end
  end
  assign syncNow = syncRun_q && !ctrl_q[B_SYNCOFF] && syncCnt_q == 5'h00 && active;
  // ----------------------------------------------------------------
  // decimation front end
  // ----------------------------------------------------------------
  logic          phase_q;
  logic [DW-1:0] held_q, decWord_q, din;
  logic [12:0]   sumA, sumB;
  assign sumA = 13'(held_q[DW-1:SAMPLE_W]) + 13'(chanAData);
  assign sumB = 13'(held_q[SAMPLE_W-1:0]) + 13'(chanBData);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q   <= 1'b0;
      held_q    <= '0;
      decWord_q <= '0;
    end else if (ce) begin
      if (syncStart || !decimEn) begin
        phase_q <= 1'b0;
      end else begin
        phase_q <= ~phase_q;
      end
      if (!phase_q) begin
        held_q <= {chanAData, chanBData};
      end else begin
        decWord_q <= {sumA[12:1], sumB[12:1]};
      end
    end
  end
  assign din = decimEn ? decWord_q : {chanAData, chanBData};
  // ----------------------------------------------------------------
  // latency delay lines
  // ----------------------------------------------------------------
  logic [DW-1:0] dly_q [LAT_DECIM];
  logic [1:0]    ovrDly_q [LAT_OVR];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LAT_DECIM; i++) dly_q[i] <= '0;
    end else if (ce) begin
      dly_q[0] <= din;
      for (int i = 1; i < LAT_DECIM; i++) dly_q[i] <= dly_q[i-1];
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LAT_OVR; i++) ovrDly_q[i] <= 2'h0;
    end else if (ce) begin
      ovrDly_q[0] <= {chanAOver, chanBOver};
      for (int i = 1; i < LAT_OVR; i++) ovrDly_q[i] <= ovrDly_q[i-1];
    end
  end
  logic [6:0]    tapIdx;
  logic [DW-1:0] tapWord;
  logic [1:0]    ovrTap;
  assign tapIdx  = decimEn ? 7'(LAT_DECIM - 2) : autoCor ? 7'(LAT_AUTO - 2)
                   : 7'(LAT_PLAIN - 2);
  assign tapWord = dly_q[tapIdx];
  assign ovrTap  = ovrDly_q[LAT_OVR-2];
  // ----------------------------------------------------------------
  // output buses and forwarded clocks
  // ----------------------------------------------------------------
  logic                wordStrobe, fwdPhase_q, aClk_q, bClk_q;
  logic [SAMPLE_W-1:0] busA_q, busB_q;
  assign wordStrobe = !decimEn || phase_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busA_q     <= '0;
      busB_q     <= '0;
      fwdPhase_q <= 1'b0;
      aClk_q     <= 1'b0;
      bClk_q     <= 1'b0;
    end else if (ce) begin
      if (!active) begin
        busA_q <= '0;
        busB_q <= '0;
      end else if (wordStrobe) begin
        busA_q     <= tapWord[DW-1:SAMPLE_W];
        busB_q     <= tapWord[SAMPLE_W-1:0];
        fwdPhase_q <= syncStart ? 1'b0 : ~fwdPhase_q;
        aClk_q     <= ~fwdPhase_q ^ edgeA;
        bClk_q     <= ~fwdPhase_q ^ (bOnA ? edgeA : edgeB);
      end
    end
  end
  assign busASample   = busA_q;
  assign busBSample   = busB_q;
  assign busAFwdClock = aClk_q;
  assign busBFwdClock = bClk_q;
  // ----------------------------------------------------------------
  // overrange and sync pins
  // ----------------------------------------------------------------
  logic ovrA_q, ovrB_q, syncOut_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovrA_q    <= 1'b0;
      ovrB_q    <= 1'b0;
      syncOut_q <= 1'b0;
    end else if (ce) begin
      syncOut_q <= syncNow;
      ovrA_q    <= ctrl_q[B_OVRASYN] ? syncNow : active & ovrTap[1];
      ovrB_q    <= ctrl_q[B_OVRBSYN] ? syncNow : active & ovrTap[0];
    end
  end
  assign chanAOverrange = ovrA_q;
  assign chanBOverrange = ovrB_q;
  assign syncOut        = syncOut_q;
  // ----------------------------------------------------------------
  // status, mask and interrupt
  // ----------------------------------------------------------------
  logic [ST_W-1:0] stat_q, mask_q, evt, clr;
  logic            irq_q;
  assign evt = {cfgBus.we, syncStart, active & ovrTap[0], active & ovrTap[1]};
  assign clr = (apbWr && paddr == STAT_OFS) ? pwdata[ST_W-1:0] : '0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= '0;
      mask_q <= MASK_RST;
      irq_q  <= 1'b0;
    end else if (ce) begin
      stat_q <= (stat_q & ~clr) | evt;
      if (apbWr && paddr == MASK_OFS) begin
        mask_q <= pwdata[ST_W-1:0];
      end
      irq_q <= |(stat_q & mask_q);
    end
  end
  assign irq = irq_q;
  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic [31:0] rdVal;
  logic        hit;
  always_comb begin
    rdVal = 32'h00000000;
    hit   = 1'b1;
    if (paddr == CTRL_OFS) begin
      rdVal = 32'(ctrl_q);
    end else if (paddr == STAT_OFS) begin
      rdVal = 32'(stat_q);
    end else if (paddr == MASK_OFS) begin
      rdVal = 32'(mask_q);
    end else if (paddr == INFO_OFS) begin
      rdVal = {29'h00000000, syncRun_q, active, ctrl_q[B_FOURW]};
    end else begin
      hit = 1'b0;
    end
  end
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q  <= apbSetup;
      pslverr_q <= apbSetup & ~hit;
      if (apbSetup) begin
        prdata_q <= pwrite ? 32'h00000000 : rdVal;
      end
    end
  end
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [6:0] calm_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      calm_q <= 7'h00;
    end else if (!ce || !active || cfgBus.we || apbWr || syncStart) begin
      calm_q <= 7'h00;
    end else if (calm_q != 7'h64) begin
      calm_q <= calm_q + 7'h01;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);
  sequence s_sync_rise;
    syncStart;
  endsequence
  sequence s_sync_running;
    syncRun_q && syncCnt_q == 5'h00 ##1 syncCnt_q == 5'h01;
  endsequence
  a_sync_start_run: assert property (s_sync_rise |=> s_sync_running)
    else $error("sync start did not restart timing");
  a_cfg_reset_val: assert property (!serialPortReset_n |-> ctrl_q == CTRL_RST)
    else $error("config not at default during serial reset");
  a_cfg_default_mode: assert property ($rose(serialPortReset_n)
    |-> !ctrl_q[B_FOURW] && !ctrl_q[B_SYNCOFF] && !decimEn) else $error("bad defaults");
  a_power_down_quiet: assert property (!active |=> busA_q == '0 && busB_q == '0)
    else $error("bus not quiet while powered down");
  a_plain_latency: assert property (calm_q == 7'h64 && !decimEn && !autoCor
    |-> busA_q == $past(chanAData, 38)) else $error("plain latency wrong");
  a_auto_latency: assert property (calm_q == 7'h64 && !decimEn && autoCor
    |-> busB_q == $past(chanBData, 50)) else $error("auto correction latency wrong");
  a_ovr_latency: assert property (calm_q == 7'h64 && !ctrl_q[B_OVRASYN]
    |-> ovrA_q == $past(chanAOver, 12)) else $error("overrange latency wrong");
  a_ovr_carry_sync: assert property (ctrl_q[B_OVRBSYN] |=> ovrB_q == syncOut_q)
    else $error("overrange pin not carrying sync");
  a_sync_out_off: assert property (ctrl_q[B_SYNCOFF] |=> !syncOut_q)
    else $error("sync output not disabled");
  a_fwd_clk_toggle: assert property (active && !decimEn && !syncStart && $stable(ctrl_q)
    |=> aClk_q != $past(aClk_q)) else $error("bus A clock not toggling");
  a_bclk_follow_a: assert property (active && bOnA |=> bClk_q == aClk_q)
    else $error("bus B clock not aligned to bus A");
  a_decim_hold: assert property (calm_q == 7'h64 && decimEn
    && busA_q != $past(busA_q) |=> $stable(busA_q)) else $error("decimated rate too high");
endmodule

// ---- testbench/daoc_host_model.sv ----
`timescale 1ns/1ps
module daoc_host_model (
  input  wire logic clk,
  input  wire logic ioOut,
  input  wire logic ioOe,
  input  wire logic dataOut,
  input  wire logic dataOutOe,
  output logic      serialClock,
  output logic      serialSelect,
  output logic      sdioLevel
);
  logic hostDrv, hostBit, ioSeen, outSeen, lastBit;
  // a released data pin falls to its pull-down level
  assign sdioLevel = ioOe ? ioOut : (hostDrv & hostBit);
  initial begin
    serialClock = 1'b0;
    serialSelect = 1'b0;
    hostDrv = 1'b0;
    hostBit = 1'b0;
  end
  // samples pins mid-cycle, away from the design's clock edge
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clk);
      ioSeen = ioSeen | (ioOe === 1'b1);
      outSeen = outSeen | (dataOutOe === 1'b1);
      lastBit = sdioLevel | (dataOutOe & dataOut);
      @(posedge clk);
    end
  endtask
  task automatic frame(input logic [31:0] sh, output logic [23:0] rdv, output logic io,
                       output logic out);
    ioSeen = 1'b0;
    outSeen = 1'b0;
    serialSelect <= 1'b1;
    tick(8);
    for (int i = 31; i >= 0; i--) begin
      hostDrv <= !(sh[31] && i < 24);
      hostBit <= sh[i];
      tick(8);
      serialClock <= 1'b1;
      if (i < 24) rdv[i] = lastBit;
      tick(2);
      // hold the last header bit until the device has sampled it
      if (sh[31] && i == 24) hostDrv <= 1'b0;
      tick(6);
      serialClock <= 1'b0;
    end
    tick(8);
    serialSelect <= 1'b0;
    hostDrv <= 1'b0;
    tick(16);
    io = ioSeen;
    out = outSeen;
  endtask
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import daoc_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        chipEnable = 1'b0, syncIn = 1'b0, serialPortReset_n = 1'b1;
  logic        chanAOver = 1'b0, chanBOver = 1'b0, sclk, ssel, sdi, ioOut, ioOe, serial_data_out, sdoOe;
  logic        pready, pslverr, irq, fwdA, fwdB, ovrA, ovrB, syncOut, io, out, e, fwdPrev;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [11:0] chanAData = 12'h000, chanBData = 12'h000, busA, busB;
  logic [11:0] histA [128], histB [128];
  logic        histO [128];
  logic [23:0] sd;
  int          failures, n_tests, cyc, lat, chkOn, syncCnt, ovrCnt, tglCnt;
  daoc_core daoc_core_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .chipEnable(chipEnable),
    .syncIn(syncIn), .serialPortReset_n(serialPortReset_n), .serialClock(sclk),
    .serialSelect(ssel), .serialDataIn(sdi), .serialDataIoOut(ioOut), .serialDataIoOe(ioOe),
    .serialDataOut(serial_data_out), .serialDataOutOe(sdoOe), .chanAData(chanAData),
    .chanBData(chanBData), .chanAOver(chanAOver), .chanBOver(chanBOver),
    .busASample(busA), .busBSample(busB), .busAFwdClock(fwdA), .busBFwdClock(fwdB),
    .chanAOverrange(ovrA), .chanBOverrange(ovrB), .syncOut(syncOut));
  daoc_host_model daoc_host_model_inst (.clk(clk), .ioOut(ioOut), .ioOe(ioOe),
    .dataOut(serial_data_out), .dataOutOe(sdoOe), .serialClock(sclk), .serialSelect(ssel),
    .sdioLevel(sdi));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish;
    if (failures == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic win(input int l, input int on);
    lat = l;
    repeat (100) @(posedge clk);
    chkOn = on;
    tglCnt = 0;
    repeat (64) @(posedge clk);
    chkOn = 0;
  endtask
  task automatic pulses;
    repeat (4) @(posedge clk);
    syncCnt = 0;
    ovrCnt = 0;
    repeat (64) @(posedge clk);
  endtask
  // sample stream: both bus outputs compared with the input seen lat cycles before, ovr a with LAT_OVR cycles before
  always @(posedge clk) begin
    chanAData <= chanAData + 12'h001;
    chanBData <= chanBData - 12'h003;
    chanAOver <= chanAData[2];
    chanBOver <= chanBData[3];
  end
  always @(negedge clk) begin
    histA[cyc % 128] = chanAData;
    histB[cyc % 128] = chanBData;
    histO[cyc % 128] = chanAOver;
    if (chkOn != 0) begin
      check("bus a", busA, histA[(cyc - lat) % 128]);
      check("bus b", busB, histB[(cyc - lat) % 128]);
      check("ovr a", ovrA, histO[(cyc - LAT_OVR) % 128]);
    end
    syncCnt += (syncOut === 1'b1);
    ovrCnt += (ovrA === 1'b1) + (ovrB === 1'b1);
    tglCnt += (fwdA !== fwdPrev);
    fwdPrev = fwdA;
    cyc++;
  end
  initial begin
    #100000;
    failures++;
    tally_and_finish;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, CTRL_OFS, 32'h0);
    check("ctrl", r, {8'h00, CTRL_RST});
    apb(1'b0, MASK_OFS, 32'h0);
    check("mask", r, {28'h0, MASK_RST});
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped err", e, 1);
    check("unmapped data", r, 0);
    chipEnable <= 1'b1;
    win(LAT_PLAIN, 1);
    check("fwd toggles", tglCnt, 64);
    apb(1'b1, CTRL_OFS, 32'h1 << B_AUTOCOR);
    win(LAT_AUTO, 1);
    apb(1'b1, CTRL_OFS, 32'h1 << B_DECIM);
    win(0, 0);
    check("decim toggles", tglCnt, 32);
    apb(1'b1, CTRL_OFS, 32'h1 << B_PWRDN);
    win(0, 0);
    check("power down", busA, 0);
    apb(1'b1, CTRL_OFS, 32'h0);
    chipEnable <= 1'b0;
    win(0, 0);
    check("chip off", busA, 0);
    check("sync idle", syncCnt, 0);
    chipEnable <= 1'b1;
    syncIn <= 1'b1;
    win(0, 0);
    apb(1'b0, STAT_OFS, 32'h0);
    check("sync status", r[ST_SYNC], 1);
    check("masked irq", irq, 0);
    apb(1'b1, MASK_OFS, 32'h1 << ST_SYNC);
    repeat (3) @(posedge clk);
    check("irq", irq, 1);
    apb(1'b1, STAT_OFS, 32'h1 << ST_SYNC);
    repeat (3) @(posedge clk);
    check("irq cleared", irq, 0);
    pulses;
    check("sync pulses", syncCnt, 4);
    apb(1'b1, CTRL_OFS, 32'h1 << B_SYNCOFF);
    pulses;
    check("sync off", syncCnt, 0);
    apb(1'b1, CTRL_OFS, (32'h1 << B_OVRASYN) | (32'h1 << B_OVRBSYN) | (32'h1 << B_BONA)
        | (32'h1 << B_EDGEB));
    pulses;
    check("ovr carries sync", ovrCnt, 8);
    check("b on a clock", fwdB, fwdA);
    daoc_host_model_inst.frame(32'h00010000, sd, io, out);
    apb(1'b0, INFO_OFS, 32'h0);
    check("four wire", r[0], 1);
    daoc_host_model_inst.frame(32'h80000000, sd, io, out);
    check("sdo data", sd, 24'h010000);
    check("sdio input only", io, 0);
    check("sdo driven", out, 1);
    serialPortReset_n <= 1'b0;
    @(posedge clk);
    serialPortReset_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, CTRL_OFS, 32'h0);
    check("serial reset", r, 0);
    apb(1'b1, CTRL_OFS, 32'h00a5a2);
    daoc_host_model_inst.frame(32'h80000000, sd, io, out);
    check("sdio data", sd, 24'h00a5a2);
    check("sdio driven", io, 1);
    check("sdo released", out, 0);
    tally_and_finish;
  end
endmodule
